// >>> include/sdram_cfg_regs.svh
// offsets, field positions, codes and counts of the configuration registers
`ifndef SDRAM_CFG_REGS_SVH
`define SDRAM_CFG_REGS_SVH
// main configuration word {bank_select_hi, bank_select_lo, addr[11:0]}
`define LEN_CODE_LSB      0
`define LEN_CODE_MSB      2
`define ORDER_SELECT_BIT  3
`define LAT_CODE_LSB      4
`define LAT_CODE_MSB      6
`define OPMODE_BIT_LO     7
`define OPMODE_BIT_HI     8
`define WRITE_SINGLE_BIT  9
`define MAIN_CFG_RESET    14'h0000
`define LEN_CODE_1        3'h0
`define LEN_CODE_2        3'h1
`define LEN_CODE_4        3'h2
`define LEN_CODE_8        3'h3
`define LAT_CODE_2        3'h2
`define LAT_CODE_3        3'h3
// bank select values of the load command
`define BANK_SEL_MAIN     2'h0
`define BANK_SEL_EXT      2'h2
// extended configuration word
`define RGN_LSB           0
`define RGN_MSB           2
`define TEMP_LSB          3
`define TEMP_MSB          4
`define EXT_CFG_RESET     12'h000
`define RGN_ALL           3'h0
`define RGN_TWO_BANKS     3'h1
`define RGN_ONE_BANK      3'h2
`define RGN_HALF_BANK     3'h5
`define RGN_QUARTER_BANK  3'h6
// wait after a register load, in clock cycles
`define CFG_LOAD_WAIT_CYC 4'h2
`endif

// >>> include/sdram_cfg_pkg.sv
// shared types of the sdram configuration ends
package sdram_cfg_pkg;
   typedef enum logic [2:0] {CMD_NOP, CMD_LOAD, CMD_READ, CMD_WRITE, CMD_REFRESH, CMD_OTHER} cmd_kind_t;
   typedef enum logic [1:0] {REQ_LOAD_MAIN, REQ_LOAD_EXT, REQ_READ, REQ_WRITE} req_kind_t;

   function automatic cmd_kind_t decode_cmd(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
      cmd_kind_t k;
      k = CMD_OTHER;
      if (cs_n || (ras_n && cas_n && we_n))
         k = CMD_NOP;
      else if (!ras_n && !cas_n)
         k = we_n ? CMD_REFRESH : CMD_LOAD;
      else if (ras_n && !cas_n)
         k = we_n ? CMD_READ : CMD_WRITE;
      return k;
   endfunction : decode_cmd
endpackage : sdram_cfg_pkg

// >>> include/sdram_link_if.sv
// command/address/data link between controller and sdram device
`timescale 1ns/1ps
interface sdram_link_if;
   logic        cke;
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic [1:0]  ba;
   logic [11:0] addr;
   logic [15:0] ctrl_dq;
   logic        ctrl_dq_oe;
   logic [15:0] dev_dq;
   logic        dev_dq_oe;
   logic [15:0] dq;

   // resolved data wire; an undriven bus reads as zero
   assign dq = dev_dq_oe ? dev_dq : (ctrl_dq_oe ? ctrl_dq : 16'h0000);

   modport device (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq,
                   output dev_dq, dev_dq_oe);
   modport controller (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, ctrl_dq, ctrl_dq_oe,
                       input dq);
endinterface : sdram_link_if

// >>> design/burst_col_gen.sv
// column address of one beat within a wrapped burst block
`timescale 1ns/1ps
module burst_col_gen (
   // burst description
   input  wire logic [8:0] start_col_i,
   input  wire logic [2:0] beat_i,
   input  wire logic [1:0] len_log_i,
   input  wire logic       interleave_i,
   // result
   output logic      [8:0] col_o
);
   logic [2:0] mask;
   logic [2:0] low;

   always_comb
   begin
      mask = 3'((4'h1 << len_log_i) - 4'h1);
      if (interleave_i)
         low = start_col_i[2:0] ^ beat_i;
      else
         low = start_col_i[2:0] + beat_i;
      // bits above the block size stay fixed, so the burst wraps
      col_o = {start_col_i[8:3], (low & mask) | (start_col_i[2:0] & ~mask)};
   end
endmodule : burst_col_gen

// >>> design/sdram_cfg_device.sv
// sdram device end: configuration registers, burst sequencing, read latency
// ----------------------------------------------------------------------------
// Notes on behaviour
// - main config held until next load
// - main word fields: length, order, latency, mode, write
// - controller zeroes bits 10-11 and bank selects
// - controller loads only idle, waits load delay
// - burst lengths 1, 2, 4, 8, both orders
// - burst wraps inside aligned block of length
// - bit 3 selects sequential or interleaved order
// - sequential: start plus count modulo length
// - interleaved: start xor count
// - read latency two or three cycles
// - drive from n+m-1, valid by n+m
// - controller programs operating mode bits zero
// - write-single bit makes writes one location
// - extended register loaded with bank select 10
// - extended load only idle, then wait
// - temperature bits ignored, sensor rules refresh
// - controller zeroes temperature bits
// - self refresh covers only selected region
// - all banks usable, unselected lost in refresh
// - load command: all strobes low, clock enable high
// - opcode taken from twelve address inputs
// - controller loads main config before use
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "sdram_cfg_regs.svh"
module sdram_cfg_device (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // link to the controller
   sdram_link_if.device     link,
   // array access per beat
   output logic             access_valid_o,
   output logic             access_write_o,
   output logic [1:0]       access_bank_o,
   output logic [8:0]       access_col_o,
   output logic [15:0]      wr_data_o,
   input  wire logic [15:0] rd_data_i,
   // refresh status
   output logic             self_refresh_o,
   output logic [3:0]       refresh_bank_mask_o,
   output logic [1:0]       refresh_row_msbs_o
);
   sdram_cfg_pkg::cmd_kind_t cmd;
   logic [13:0] main_cfg;
   logic [11:0] ext_cfg;
   logic        cmd_load;
   logic        cmd_rd;
   logic        cmd_wr;
   logic        start_burst;
   logic [2:0]  len_code;
   logic [1:0]  len_log;
   logic [1:0]  cmd_log;
   logic        lat3;
   // burst state
   logic        active;
   logic        write_burst;
   logic [2:0]  beat;
   logic [1:0]  burst_log;
   logic        burst_order;
   logic [8:0]  start_col;
   logic [1:0]  burst_bank;
   logic        burst_lat3;
   logic [2:0]  last_beat;
   logic        continuing;
   logic [8:0]  gen_start;
   logic [2:0]  gen_beat;
   logic [1:0]  gen_log;
   logic        gen_order;
   logic [8:0]  gen_col;
   // read pipeline
   logic [15:0] pipe_data;
   logic        pipe_oe;
   logic        rd_take;

   // ---------------------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------------------
   always_comb
   begin
      cmd         = sdram_cfg_pkg::decode_cmd(link.cs_n, link.ras_n, link.cas_n, link.we_n);
      // with the clock enable low no load, read or write is executed
      cmd_load    = link.cke && (cmd == sdram_cfg_pkg::CMD_LOAD);
      cmd_rd      = link.cke && (cmd == sdram_cfg_pkg::CMD_READ);
      cmd_wr      = link.cke && (cmd == sdram_cfg_pkg::CMD_WRITE);
      start_burst = cmd_rd || cmd_wr;
   end

   // ---------------------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         main_cfg <= `MAIN_CFG_RESET;
      else if (cmd_load && (link.ba == `BANK_SEL_MAIN))
         main_cfg <= {link.ba, link.addr};
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         ext_cfg <= `EXT_CFG_RESET;
      else if (cmd_load && (link.ba == `BANK_SEL_EXT))
         ext_cfg <= link.addr;
   end

   always_comb
   begin
      len_code = main_cfg[`LEN_CODE_MSB:`LEN_CODE_LSB];
      // reserved length codes fall back to single-location bursts
      unique case (len_code)
         `LEN_CODE_2: len_log = 2'h1;
         `LEN_CODE_4: len_log = 2'h2;
         `LEN_CODE_8: len_log = 2'h3;
         default:     len_log = 2'h0;
      endcase
      cmd_log = (cmd_wr && main_cfg[`WRITE_SINGLE_BIT]) ? 2'h0 : len_log;
      // only the two-cycle code picks two; anything else runs at three
      lat3    = main_cfg[`LAT_CODE_MSB:`LAT_CODE_LSB] != `LAT_CODE_2;
   end

   // ---------------------------------------------------------------------------
   // burst sequencing
   // ---------------------------------------------------------------------------
   always_comb
   begin
      last_beat  = 3'((4'h1 << burst_log) - 4'h1);
      continuing = active && (beat != last_beat);
      gen_start  = start_burst ? link.addr[8:0] : start_col;
      gen_beat   = start_burst ? 3'h0 : 3'(beat + 3'h1);
      gen_log    = start_burst ? cmd_log : burst_log;
      gen_order  = start_burst ? main_cfg[`ORDER_SELECT_BIT] : burst_order;
   end

   burst_col_gen u_col_gen (
      .start_col_i  (gen_start),
      .beat_i       (gen_beat),
      .len_log_i    (gen_log),
      .interleave_i (gen_order),
      .col_o        (gen_col)
   );

   // settings are sampled per command, so a new load governs the next one
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         active      <= 1'b0;
         write_burst <= 1'b0;
         beat        <= 3'h0;
         burst_log   <= 2'h0;
         burst_order <= 1'b0;
         start_col   <= 9'h000;
         burst_bank  <= 2'h0;
         burst_lat3  <= 1'b1;
      end
      else if (start_burst)
      begin
         // a new read or write cuts short any burst still running
         active      <= 1'b1;
         write_burst <= cmd_wr;
         beat        <= 3'h0;
         burst_log   <= cmd_log;
         burst_order <= main_cfg[`ORDER_SELECT_BIT];
         start_col   <= link.addr[8:0];
         burst_bank  <= link.ba;
         if (cmd_rd)
            burst_lat3 <= lat3;
      end
      else if (continuing)
         beat <= 3'(beat + 3'h1);
      else
         active <= 1'b0;
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         access_valid_o <= 1'b0;
         access_write_o <= 1'b0;
         access_bank_o  <= 2'h0;
         access_col_o   <= 9'h000;
         wr_data_o      <= 16'h0000;
      end
      else
      begin
         access_valid_o <= start_burst || continuing;
         access_write_o <= start_burst ? cmd_wr : write_burst;
         access_bank_o  <= start_burst ? link.ba : burst_bank;
         access_col_o   <= gen_col;
         wr_data_o      <= link.dq;
      end
   end

   // ---------------------------------------------------------------------------
   // read data path
   // ---------------------------------------------------------------------------
   // beat k is looked up in the cycle after edge n+k and launched at n+k+m-1
   assign rd_take = access_valid_o && !access_write_o;

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         pipe_data      <= 16'h0000;
         pipe_oe        <= 1'b0;
         link.dev_dq    <= 16'h0000;
         link.dev_dq_oe <= 1'b0;
      end
      else
      begin
         pipe_data      <= rd_data_i;
         pipe_oe        <= rd_take;
         link.dev_dq    <= burst_lat3 ? pipe_data : rd_data_i;
         link.dev_dq_oe <= burst_lat3 ? pipe_oe : rd_take;
      end
   end

   // ---------------------------------------------------------------------------
   // self refresh region
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         self_refresh_o <= 1'b0;
      else if (link.cke)
         self_refresh_o <= 1'b0;
      else if (cmd == sdram_cfg_pkg::CMD_REFRESH)
         self_refresh_o <= 1'b1;
   end

   // temperature bits are stored but never read: the sensor sets the rate
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         refresh_bank_mask_o <= 4'hF;
         refresh_row_msbs_o  <= 2'h0;
      end
      else
      begin
         unique case (ext_cfg[`RGN_MSB:`RGN_LSB])
            `RGN_TWO_BANKS:     refresh_bank_mask_o <= 4'h3;
            `RGN_ONE_BANK,
            `RGN_HALF_BANK,
            `RGN_QUARTER_BANK:  refresh_bank_mask_o <= 4'h1;
            default:            refresh_bank_mask_o <= 4'hF;
         endcase
         // count of row msbs that must be zero for a row to be kept
         unique case (ext_cfg[`RGN_MSB:`RGN_LSB])
            `RGN_HALF_BANK:     refresh_row_msbs_o <= 2'h1;
            `RGN_QUARTER_BANK:  refresh_row_msbs_o <= 2'h2;
            default:            refresh_row_msbs_o <= 2'h0;
         endcase
      end
   end
endmodule : sdram_cfg_device

// >>> design/sdram_cfg_controller.sv
// controller end: issues register loads, reads, writes and self refresh
`timescale 1ns/1ps
`include "sdram_cfg_regs.svh"
module sdram_cfg_controller (
   // clock and reset
   input  wire logic                      mclk_i,
   input  wire logic                      reset_i,
   // link to the device
   sdram_link_if.controller               link,
   // request port
   input  wire logic                      req_valid_i,
   input  wire sdram_cfg_pkg::req_kind_t  req_kind_i,
   input  wire logic [1:0]                req_ba_i,
   input  wire logic [11:0]               req_addr_i,
   output logic                           req_ready_o,
   output logic                           cfg_loaded_o,
   // write data per beat
   input  wire logic [15:0]               wr_data_i,
   output logic                           wr_data_req_o,
   // read data per beat
   output logic                           rd_valid_o,
   output logic [15:0]                    rd_data_o,
   // self refresh request, held for the whole stay
   input  wire logic                      sref_req_i
);
   typedef enum logic [2:0] {C_IDLE, C_WAIT, C_READ, C_WRITE, C_SREF} ctrl_state_t;
   ctrl_state_t state;
   logic [3:0]  cnt;
   logic [3:0]  blen;
   logic [3:0]  lat;
   logic        wsingle;
   logic        take;
   logic [3:0]  wr_len;

   // reads and writes wait for the first main load
   assign req_ready_o   = (state == C_IDLE) && !sref_req_i &&
                          (cfg_loaded_o || req_kind_i == sdram_cfg_pkg::REQ_LOAD_MAIN ||
                           req_kind_i == sdram_cfg_pkg::REQ_LOAD_EXT);
   assign take          = req_valid_i && req_ready_o;
   assign wr_len        = wsingle ? 4'h1 : blen;
   assign wr_data_req_o = (state == C_WRITE) && (cnt != wr_len);

   // ---------------------------------------------------------------------------
   // remembered settings of the last main load
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         cfg_loaded_o <= 1'b0;
         blen         <= 4'h1;
         lat          <= 4'h3;
         wsingle      <= 1'b0;
      end
      else if (take && req_kind_i == sdram_cfg_pkg::REQ_LOAD_MAIN)
      begin
         cfg_loaded_o <= 1'b1;
         blen         <= (req_addr_i[`LEN_CODE_MSB:`LEN_CODE_LSB] == `LEN_CODE_8) ? 4'h8 :
                         (req_addr_i[`LEN_CODE_MSB:`LEN_CODE_LSB] == `LEN_CODE_4) ? 4'h4 :
                         (req_addr_i[`LEN_CODE_MSB:`LEN_CODE_LSB] == `LEN_CODE_2) ? 4'h2 : 4'h1;
         lat          <= (req_addr_i[`LAT_CODE_MSB:`LAT_CODE_LSB] == `LAT_CODE_2) ? 4'h2 : 4'h3;
         wsingle      <= req_addr_i[`WRITE_SINGLE_BIT];
      end
   end

   // ---------------------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         state <= C_IDLE;
         cnt   <= 4'h0;
      end
      else
      begin
         unique case (state)
            C_IDLE:
            begin
               cnt <= 4'h0;
               if (sref_req_i)
                  state <= C_SREF;
               else if (take && req_kind_i == sdram_cfg_pkg::REQ_READ)
                  state <= C_READ;
               else if (take && req_kind_i == sdram_cfg_pkg::REQ_WRITE)
               begin
                  state <= C_WRITE;
                  cnt   <= 4'h1;
               end
               else if (take)
                  state <= C_WAIT;
            end
            // nothing follows a load before the wait is over
            C_WAIT:
            begin
               cnt <= 4'(cnt + 4'h1);
               if (cnt == 4'(`CFG_LOAD_WAIT_CYC - 4'h1))
                  state <= C_IDLE;
            end
            C_READ:
            begin
               cnt <= 4'(cnt + 4'h1);
               if (cnt == 4'(lat + blen - 4'h1))
                  state <= C_IDLE;
            end
            C_WRITE:
            begin
               cnt <= 4'(cnt + 4'h1);
               if (cnt == wr_len)
                  state <= C_IDLE;
            end
            C_SREF:
               if (!sref_req_i)
                  state <= C_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // command and address outputs
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         link.cke   <= 1'b1;
         link.ras_n <= 1'b1;
         link.cas_n <= 1'b1;
         link.we_n  <= 1'b1;
         link.ba    <= 2'h0;
         link.addr  <= 12'h000;
      end
      else
      begin
         link.cke   <= 1'b1;
         link.ras_n <= 1'b1;
         link.cas_n <= 1'b1;
         link.we_n  <= 1'b1;
         if (state == C_IDLE && sref_req_i)
         begin
            // self refresh entry; the clock enable stays low until release
            link.cke   <= 1'b0;
            link.ras_n <= 1'b0;
            link.cas_n <= 1'b0;
         end
         else if (state == C_SREF)
            link.cke <= !sref_req_i;
         else if (take)
         begin
            link.ba   <= req_ba_i;
            link.addr <= req_addr_i;
            unique case (req_kind_i)
               sdram_cfg_pkg::REQ_LOAD_MAIN:
               begin
                  {link.ras_n, link.cas_n, link.we_n} <= 3'h0;
                  link.ba <= `BANK_SEL_MAIN;
                  link.addr <= {2'h0, req_addr_i[9], 2'h0, req_addr_i[6:0]};
               end
               sdram_cfg_pkg::REQ_LOAD_EXT:
               begin
                  {link.ras_n, link.cas_n, link.we_n} <= 3'h0;
                  link.ba <= `BANK_SEL_EXT;
                  link.addr <= {req_addr_i[11:5], 2'h0, req_addr_i[2:0]};
               end
               sdram_cfg_pkg::REQ_READ:
                  link.cas_n <= 1'b0;
               sdram_cfg_pkg::REQ_WRITE:
               begin
                  link.cas_n <= 1'b0;
                  link.we_n  <= 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         link.cs_n       <= 1'b0;
         link.ctrl_dq    <= 16'h0000;
         link.ctrl_dq_oe <= 1'b0;
      end
      else
      begin
         link.cs_n       <= 1'b0;
         link.ctrl_dq    <= wr_data_i;
         link.ctrl_dq_oe <= (take && req_kind_i == sdram_cfg_pkg::REQ_WRITE) || wr_data_req_o;
      end
   end

   // ---------------------------------------------------------------------------
   // read capture: edge n+lat through n+lat+bl-1
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         rd_valid_o <= 1'b0;
         rd_data_o  <= 16'h0000;
      end
      else
      begin
         rd_valid_o <= (state == C_READ) && (cnt >= lat) && (cnt < 4'(lat + blen));
         rd_data_o  <= link.dq;
      end
   end
endmodule : sdram_cfg_controller

// >>> testbench/sdram_link_checker.sv
// link assertions for the configuration and burst ends
`timescale 1ns/1ps
module sdram_link_checker (
   // clock and reset
   input wire logic        mclk_i,
   input wire logic        reset_i,
   // link signals
   input wire logic        cke,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [1:0]  ba,
   input wire logic [11:0] addr,
   input wire logic        ctrl_dq_oe,
   input wire logic        dev_dq_oe
);
   logic       ld, rd, wr;
   logic [3:0] blen, run;
   logic [2:0] lat;
   assign ld = !cs_n && !ras_n && !cas_n && !we_n;
   assign rd = cke && !cs_n && ras_n && !cas_n && we_n;
   assign wr = cke && !cs_n && ras_n && !cas_n && !we_n;
   // shadow of length and latency; reserved codes map as the device maps them
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         blen <= 4'h1;
         lat  <= 3'h3;
      end
      else if (cke && ld && ba == 2'h0)
      begin
         blen <= addr[2] ? 4'h1 : 4'h1 << addr[1:0];
         lat  <= (addr[6:4] == 3'h2) ? 3'h2 : 3'h3;
      end
   end
   always_ff @(posedge mclk_i)
      run <= (reset_i || !dev_dq_oe) ? 4'h0 : run + 4'h1;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   sequence s_quiet2;
      (cs_n || (ras_n && cas_n && we_n)) [*2];
   endsequence
   sequence s_lat2;
      ##1 !dev_dq_oe ##1 dev_dq_oe;
   endsequence
   sequence s_lat3;
      ##1 !dev_dq_oe [*2] ##1 dev_dq_oe;
   endsequence
   a_read_lat_two: assert property (rd && lat == 3'h2 |-> s_lat2) else $error("latency two missed");
   a_read_lat_three: assert property (rd && lat == 3'h3 |-> s_lat3) else $error("latency three missed");
   a_burst_run_len: assert property (!$past(reset_i) && $fell(dev_dq_oe) |-> run == blen)
      else $error("read burst length wrong");
   a_write_no_drive: assert property (wr |-> ##1 !dev_dq_oe [*3]) else $error("device drove during write");
   a_write_data_with: assert property (wr |-> ctrl_dq_oe) else $error("write data late");
   a_load_clock_en: assert property (ld |-> cke) else $error("load without clock enable");
   a_main_zero_bits: assert property (ld && ba == 2'h0 |-> addr[11:10] == 2'h0 && addr[8:7] == 2'h0)
      else $error("main load reserved bits set");
   a_ext_temp_bits: assert property (ld && ba == 2'h2 |-> addr[4:3] == 2'h0) else $error("temp bits set");
   a_load_wait_gap: assert property (ld |=> s_quiet2) else $error("command inside load wait");
   a_one_dq_driver: assert property (!(dev_dq_oe && ctrl_dq_oe)) else $error("data bus driven twice");
endmodule : sdram_link_checker

// >>> testbench/sdram_mode_config_and_burst_order_tb.sv
// bench joining controller and device ends over the link
`timescale 1ns/1ps
module sdram_mode_config_and_burst_order_tb;
   logic mclk_i, reset_i, req_valid_i, req_ready_o, cfg_loaded_o, wr_data_req_o, rd_valid_o, sref_req_i;
   logic access_valid_o, access_write_o, self_refresh_o;
   logic [1:0]  req_ba_i, access_bank_o, refresh_row_msbs_o;
   logic [3:0]  refresh_bank_mask_o;
   logic [8:0]  access_col_o;
   logic [11:0] req_addr_i;
   logic [15:0] wr_data_i, rd_data_o, wr_data_o, rd_data_i;
   logic [56:0] rows [9];
   logic [8:0]  regn [5];
   int          n_errors, checks, k;
   sdram_cfg_pkg::req_kind_t req_kind_i;
   sdram_link_if link ();
   sdram_cfg_device sdram_cfg_device_i (.*);
   sdram_cfg_controller sdram_cfg_controller_i (.*);
   sdram_link_checker sdram_link_checker_i (.mclk_i(mclk_i), .reset_i(reset_i), .cke(link.cke), .cs_n(link.cs_n),
      .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr),
      .ctrl_dq_oe(link.ctrl_dq_oe), .dev_dq_oe(link.dev_dq_oe));
   // array returns its own bank and column, so data proves the beat order
   assign rd_data_i = {5'h00, access_bank_o, access_col_o};
   initial
   begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   always @(negedge mclk_i)
      if (wr_data_req_o === 1'b1)
         wr_data_i <= wr_data_i + 16'h0001;
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic request(input sdram_cfg_pkg::req_kind_t kind, input logic [11:0] addr);
      @(negedge mclk_i);
      req_valid_i = 1'b1;
      req_kind_i = kind;
      req_addr_i = addr;
      req_ba_i = (kind == sdram_cfg_pkg::REQ_LOAD_MAIN) ? 2'h0 : 2'h2;
      wr_data_i = 16'hA000;
      repeat (60)
         if (req_ready_o !== 1'b1)
            @(negedge mclk_i);
      if (req_ready_o !== 1'b1)
      begin
         n_errors++;
         print_verdict();
      end
      @(negedge mclk_i);
      req_valid_i = 1'b0;
   endtask : request
   task automatic do_op(input sdram_cfg_pkg::req_kind_t kind, input logic [11:0] addr, input logic [3:0] n,
                        input logic [31:0] lows);
      logic [8:0] c;
      int         b;
      b = 0;
      request(kind, addr);
      repeat (40)
      begin
         @(negedge mclk_i);
         c = (addr[8:0] & ~{5'h00, n - 4'h1}) | {6'h00, lows[30 - 4 * (b % 8) -: 3]};
         if (kind == sdram_cfg_pkg::REQ_READ && rd_valid_o === 1'b1)
         begin
            chk(rd_data_o, {7'h02, c}, "read beat");
            b++;
         end
         if (kind == sdram_cfg_pkg::REQ_WRITE && access_valid_o === 1'b1 && access_write_o === 1'b1)
         begin
            chk(rd_data_i, {7'h02, c}, "write col");
            chk(wr_data_o, 16'hA000 + 16'(b), "write data");
            b++;
         end
      end
      chk(16'(b), {12'h000, n}, "beats");
   endtask : do_op
   task automatic wait_sref(input logic lvl);
      repeat (30)
         if (self_refresh_o !== lvl)
            @(negedge mclk_i);
      chk({15'h0000, self_refresh_o}, {15'h0000, lvl}, "self refresh");
   endtask : wait_sref
   // ----------
   // stimulus
   // ----------
   initial
   begin
      {req_valid_i, sref_req_i, req_ba_i, req_addr_i, wr_data_i} = '0;
      req_kind_i = sdram_cfg_pkg::REQ_READ;
      {n_errors, checks} = '0;
      reset_i = 1'b1;
      // main word, start column, beats, low column bits of each beat
      rows = '{{12'h020, 9'h005, 4'h1, 32'h0}, {12'h021, 9'h0F1, 4'h2, 32'h1000_0000},
               {12'h032, 9'h031, 4'h4, 32'h1230_0000}, {12'h02A, 9'h031, 4'h4, 32'h1032_0000},
               {12'h023, 9'h1FB, 4'h8, 32'h3456_7012}, {12'h03B, 9'h1FD, 4'h8, 32'h5476_1032},
               {12'h02B, 9'h006, 4'h8, 32'h6745_2301}, {12'h039, 9'h001, 4'h2, 32'h1000_0000},
               {12'h017, 9'h007, 4'h1, 32'h0}}; // reserved codes: one beat, latency three
      regn = '{{3'h0, 4'hF, 2'h0}, {3'h1, 4'h3, 2'h0}, {3'h2, 4'h1, 2'h0}, {3'h5, 4'h1, 2'h1}, {3'h6, 4'h1, 2'h2}};
      repeat (3) @(negedge mclk_i);
      reset_i = 1'b0;
      chk({11'h000, cfg_loaded_o, refresh_bank_mask_o}, 16'h000F, "reset state");
      chk({15'h0000, req_ready_o}, 16'h0000, "ready before load");
      for (k = 0; k < 9; k++)
      begin
         request(sdram_cfg_pkg::REQ_LOAD_MAIN, rows[k][56:45]);
         do_op(sdram_cfg_pkg::REQ_READ, {3'h0, rows[k][44:36]}, rows[k][35:32], rows[k][31:0]);
         $display("row %0d done", k);
      end
      request(sdram_cfg_pkg::REQ_LOAD_MAIN, 12'h222);
      do_op(sdram_cfg_pkg::REQ_WRITE, 12'h006, 4'h1, 32'h0);
      do_op(sdram_cfg_pkg::REQ_READ, 12'h006, 4'h4, 32'h2301_0000);
      request(sdram_cfg_pkg::REQ_LOAD_MAIN, 12'h022);
      do_op(sdram_cfg_pkg::REQ_WRITE, 12'h006, 4'h4, 32'h2301_0000);
      $display("write tests done");
      for (k = 0; k < 5; k++)
      begin
         // temperature bits offered on every load; the mask must not care
         request(sdram_cfg_pkg::REQ_LOAD_EXT, {7'h00, 2'h3, regn[k][8:6]});
         sref_req_i = 1'b1;
         wait_sref(1'b1);
         chk({10'h000, refresh_bank_mask_o, refresh_row_msbs_o}, {10'h000, regn[k][5:0]}, "region");
         chk({15'h0000, req_ready_o}, 16'h0000, "ready in refresh");
         sref_req_i = 1'b0;
         wait_sref(1'b0);
      end
      $display("refresh tests done");
      // a second reset in mid-run must drop the loaded settings again
      reset_i = 1'b1;
      @(negedge mclk_i);
      reset_i = 1'b0;
      chk({11'h000, cfg_loaded_o, refresh_bank_mask_o}, 16'h000F, "reset again");
      $display("reset test done");
      print_verdict();
   end
endmodule : sdram_mode_config_and_burst_order_tb
